// >>> pkg/dswt_defs.svh
// Register map, field positions, reset values and timing counts of the sleep timer
// Function
// RULE1: Active state routes interrupt to processor
// RULE2: Sleep states route interrupt to wake controller
// RULE3: Count reads zero after deep-sleep exit
// RULE4: Host waits one slow edge before reading
// RULE5: Counters clocked by selectable slow oscillator
// RULE6: Register changes apply after three source cycles
// RULE7: Host clears counters four cycles before timeout
// RULE8: Clear operation selects counters individually
// RULE9: Pending interrupt stays until explicitly cleared
// RULE10: Host clears timer and controller pending
// RULE11: Host uses handler for next match
// RULE12: Two 16-bit, one 32-bit cascadable counters
// RULE13: Cascaded first counter matches at plus one
// RULE14: Third counter fires on toggle bit change
// RULE15: Clear requests cross safely, never lost twice
`ifndef DSWT_DEFS_SVH
`define DSWT_DEFS_SVH

`define DSWT_OFF_CTRL     12'h000
`define DSWT_OFF_MATCH0   12'h004
`define DSWT_OFF_MATCH1   12'h008
`define DSWT_OFF_CNT0     12'h00c
`define DSWT_OFF_CNT1     12'h010
`define DSWT_OFF_CNT2     12'h014
`define DSWT_OFF_INT_STAT 12'h018
`define DSWT_OFF_INT_MASK 12'h01c
`define DSWT_OFF_CLEAR    12'h020
`define DSWT_OFF_STATUS   12'h024

`define DSWT_CTRL_SEL     0
`define DSWT_CTRL_EN0     1
`define DSWT_CTRL_EN1     2
`define DSWT_CTRL_EN2     3
`define DSWT_CTRL_CASC01  4
`define DSWT_CTRL_CASC12  5
`define DSWT_CTRL_TBIT    8

`define DSWT_STAT_HIDE    0
`define DSWT_STAT_BUSY    1

`define DSWT_TBIT_RST     5'h0f
`define DSWT_MATCH_RST    16'hffff
`define DSWT_MASK_RST     3'h0
`define DSWT_APPLY_TICKS  3

`endif

// >>> pkg/dswt_pkg.sv
// Types shared by the sleep timer design
package dswt_pkg;

    typedef enum logic [1:0] {
        DSWT_PWR_ACTIVE = 2'h0,
        DSWT_PWR_SLEEP  = 2'h1,
        DSWT_PWR_DEEP   = 2'h2
    } dswt_pwr_t;

    typedef enum logic [1:0] {
        DSWT_ST_IDLE = 2'h1,
        DSWT_ST_WAIT = 2'h2
    } dswt_st_t;

    typedef struct packed {
        logic        clk_sel;
        logic [2:0]  en;
        logic        casc01;
        logic        casc12;
        logic [4:0]  tbit;
        logic [15:0] match0;
        logic [15:0] match1;
    } dswt_cfg_t;

endpackage

// >>> verilog/dswt_sync_edge.sv
// Two-flop synchroniser with rising-edge pulse for a slow oscillator pin
module dswt_sync_edge (
    input  wire logic clk_sys,
    input  wire logic arst_n,
    input  wire logic async_in,
    output logic      rise_q
);
    logic meta_q;
    logic sync_q;
    logic last_q;

    // First stage feeds only the second
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
            rise_q <= 1'b0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
            last_q <= sync_q;
            rise_q <= sync_q & ~last_q;
        end
    end
endmodule // dswt_sync_edge

// >>> verilog/dswt_top.sv
// Deep-sleep wake-up timer: APB registers, three slow counters, interrupt routing
//
// The register offsets and register access over APB were left to the implementer.
`include "dswt_defs.svh"
module dswt_top #(
    parameter int unsigned APPLY_TICKS = `DSWT_APPLY_TICKS
) (
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [11:0]       paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              ilo_clk_in,
    input  wire logic              wco_clk_in,
    input  wire dswt_pkg::dswt_pwr_t pwr_mode,
    output logic                   irq_cpu,
    output logic                   irq_wic
);
    ////////////////////////////////////////////////////////////////////////////////
    localparam logic [1:0] LAST_TICK = 2'(APPLY_TICKS - 1);

    dswt_pkg::dswt_cfg_t cfg_sh_q;
    dswt_pkg::dswt_cfg_t cfg_go_q;
    dswt_pkg::dswt_cfg_t cfg_act_q;
    dswt_pkg::dswt_st_t  st_q;
    dswt_pkg::dswt_pwr_t pwr_prev_q;
    logic        upd_pend_q;
    logic [2:0]  clr_pend_q;
    logic [2:0]  clr_go_q;
    logic [1:0]  wait_cnt_q;
    logic [15:0] cnt0_q;
    logic [15:0] cnt1_q;
    logic [31:0] cnt2_q;
    logic [2:0]  stat_q;
    logic [2:0]  mask_q;
    logic        hide_q;
    logic        pready_q;
    logic        pslverr_q;
    logic [31:0] prdata_q;
    logic        irq_cpu_q;
    logic        irq_wic_q;
    logic        ilo_tick;
    logic        wco_tick;
    logic        src_tick;
    logic        acc;
    logic        wr_en;
    logic        rd_phase;
    logic        hit;
    logic [31:0] rdata_d;
    logic        apply;
    logic        start;
    logic [2:0]  clr_wr;
    logic [2:0]  w1c;
    logic [15:0] m0_eff;
    logic        inc0;
    logic        inc1;
    logic        inc2;
    logic        ev0;
    logic        ev1;
    logic        ev2;
    logic [15:0] cnt0_nx;
    logic [15:0] cnt1_nx;
    logic [31:0] cnt2_nx;
    logic [2:0]  ev;
    logic        irq_any;
    logic        deep_exit;

    assign prdata  = prdata_q;
    assign pready  = pready_q;
    assign pslverr = pslverr_q;
    assign irq_cpu = irq_cpu_q;
    assign irq_wic = irq_wic_q;

    ////////////////////////////////////////////////////////////////////////////////
    // Slow oscillator edges become one-cycle enables on the system clock
    dswt_sync_edge u_ilo_edge (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .async_in (ilo_clk_in),
        .rise_q   (ilo_tick)
    );

    dswt_sync_edge u_wco_edge (
        .clk_sys  (clk_sys),
        .arst_n   (arst_n),
        .async_in (wco_clk_in),
        .rise_q   (wco_tick)
    );

    assign src_tick = cfg_act_q.clk_sel ? wco_tick : ilo_tick; // RULE5

    ////////////////////////////////////////////////////////////////////////////////
    // APB slave, one wait state
    assign acc      = psel & penable & pready_q;
    assign wr_en    = acc & pwrite;
    assign rd_phase = psel & penable & ~pready_q;
    assign clr_wr   = (wr_en && paddr == `DSWT_OFF_CLEAR) ? pwdata[2:0] : 3'h0;
    assign w1c      = (wr_en && paddr == `DSWT_OFF_INT_STAT) ? pwdata[2:0] : 3'h0;

    always_comb begin
        hit     = 1'b1;
        rdata_d = 32'h0;
        unique case (paddr)
            `DSWT_OFF_CTRL: begin
                rdata_d[`DSWT_CTRL_SEL]              = cfg_sh_q.clk_sel;
                rdata_d[`DSWT_CTRL_EN2:`DSWT_CTRL_EN0] = cfg_sh_q.en;
                rdata_d[`DSWT_CTRL_CASC01]           = cfg_sh_q.casc01;
                rdata_d[`DSWT_CTRL_CASC12]           = cfg_sh_q.casc12;
                rdata_d[`DSWT_CTRL_TBIT +: 5]        = cfg_sh_q.tbit;
            end
            `DSWT_OFF_MATCH0:   rdata_d[15:0] = cfg_sh_q.match0;
            `DSWT_OFF_MATCH1:   rdata_d[15:0] = cfg_sh_q.match1;
            `DSWT_OFF_CNT0:     rdata_d[15:0] = hide_q ? 16'h0 : cnt0_q; // RULE3
            `DSWT_OFF_CNT1:     rdata_d[15:0] = hide_q ? 16'h0 : cnt1_q; // RULE3
            `DSWT_OFF_CNT2:     rdata_d       = hide_q ? 32'h0 : cnt2_q; // RULE3
            `DSWT_OFF_INT_STAT: rdata_d[2:0]  = stat_q;
            `DSWT_OFF_INT_MASK: rdata_d[2:0]  = mask_q;
            `DSWT_OFF_CLEAR:    rdata_d[2:0]  = clr_pend_q | clr_go_q;
            `DSWT_OFF_STATUS: begin
                rdata_d[`DSWT_STAT_HIDE] = hide_q;
                rdata_d[`DSWT_STAT_BUSY] = (st_q == dswt_pkg::DSWT_ST_WAIT) | upd_pend_q
                                         | (|clr_pend_q);
            end
            default:            hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pready_q  <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q  <= 32'h0;
        end else begin
            pready_q  <= rd_phase;
            pslverr_q <= rd_phase & ~hit;
            if (rd_phase && !pwrite) begin
                prdata_q <= rdata_d;
            end
        end
    end

    // Control and match writes land in a shadow copy; the counters never see it directly; mask writes act at once
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg_sh_q        <= '0;
            cfg_sh_q.tbit   <= `DSWT_TBIT_RST;
            cfg_sh_q.match0 <= `DSWT_MATCH_RST;
            cfg_sh_q.match1 <= `DSWT_MATCH_RST;
            mask_q          <= `DSWT_MASK_RST;
        end else if (wr_en) begin
            if (paddr == `DSWT_OFF_CTRL) begin
                cfg_sh_q.clk_sel <= pwdata[`DSWT_CTRL_SEL];
                cfg_sh_q.en      <= pwdata[`DSWT_CTRL_EN2:`DSWT_CTRL_EN0];
                cfg_sh_q.casc01  <= pwdata[`DSWT_CTRL_CASC01];
                cfg_sh_q.casc12  <= pwdata[`DSWT_CTRL_CASC12];
                cfg_sh_q.tbit    <= pwdata[`DSWT_CTRL_TBIT +: 5];
            end
            if (paddr == `DSWT_OFF_MATCH0) begin
                cfg_sh_q.match0 <= pwdata[15:0];
            end
            if (paddr == `DSWT_OFF_MATCH1) begin
                cfg_sh_q.match1 <= pwdata[15:0];
            end
            if (paddr == `DSWT_OFF_INT_MASK) begin
                mask_q <= pwdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Apply sequencer: snapshot, wait for source edges, then commit
    assign start = (st_q == dswt_pkg::DSWT_ST_IDLE) & (upd_pend_q | (|clr_pend_q));
    assign apply = (st_q == dswt_pkg::DSWT_ST_WAIT) & src_tick
                 & (wait_cnt_q == LAST_TICK); // RULE6

    // New requests during a snapshot stay pending, so none is dropped or doubled
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            upd_pend_q <= 1'b0;
            clr_pend_q <= 3'h0;
        end else begin
            upd_pend_q <= (upd_pend_q & ~start) | (wr_en & (paddr == `DSWT_OFF_CTRL
                        || paddr == `DSWT_OFF_MATCH0 || paddr == `DSWT_OFF_MATCH1));
            clr_pend_q <= (clr_pend_q & {3{~start}}) | clr_wr; // RULE15
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            st_q       <= dswt_pkg::DSWT_ST_IDLE;
            wait_cnt_q <= 2'h0;
            cfg_go_q   <= '0;
            clr_go_q   <= 3'h0;
        end else begin
            unique case (st_q)
                dswt_pkg::DSWT_ST_IDLE: begin
                    if (start) begin
                        st_q       <= dswt_pkg::DSWT_ST_WAIT;
                        wait_cnt_q <= 2'h0;
                        cfg_go_q   <= cfg_sh_q;
                        clr_go_q   <= clr_pend_q; // RULE15
                    end
                end
                dswt_pkg::DSWT_ST_WAIT: begin
                    if (apply) begin
                        st_q     <= dswt_pkg::DSWT_ST_IDLE;
                        clr_go_q <= 3'h0;
                    end else if (src_tick) begin
                        wait_cnt_q <= wait_cnt_q + 2'h1; // RULE6
                    end
                end
                default: st_q <= dswt_pkg::DSWT_ST_IDLE;
            endcase
        end
    end

    // Reset value equals the shadow reset so counters start disabled
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cfg_act_q        <= '0;
            cfg_act_q.tbit   <= `DSWT_TBIT_RST;
            cfg_act_q.match0 <= `DSWT_MATCH_RST;
            cfg_act_q.match1 <= `DSWT_MATCH_RST;
        end else if (apply) begin
            cfg_act_q <= cfg_go_q; // RULE6
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Counters; free-running, never reset on a match
    assign m0_eff  = cfg_act_q.casc01 ? cfg_act_q.match0 + 16'h1 : cfg_act_q.match0; // RULE13
    // Event on the tick that reaches the match, so the count shows it; zero fires on wrap
    assign inc0    = src_tick & cfg_act_q.en[0];
    assign cnt0_nx = cnt0_q + 16'h1;
    assign ev0     = inc0 & (cnt0_nx == m0_eff); // RULE13
    assign inc1    = cfg_act_q.en[1] & (cfg_act_q.casc01 ? ev0 : src_tick); // RULE12
    assign cnt1_nx = cnt1_q + 16'h1;
    assign ev1     = inc1 & (cnt1_nx == cfg_act_q.match1); // RULE13
    assign inc2    = cfg_act_q.en[2] & (cfg_act_q.casc12 ? ev1 : src_tick); // RULE12
    assign cnt2_nx = cnt2_q + 32'h1;
    assign ev2     = inc2 & (cnt2_q[cfg_act_q.tbit] != cnt2_nx[cfg_act_q.tbit]); // RULE14
    assign ev      = {ev2, ev1, ev0};

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt0_q <= 16'h0;
            cnt1_q <= 16'h0;
            cnt2_q <= 32'h0;
        end else begin
            if (apply && clr_go_q[0]) begin
                cnt0_q <= 16'h0; // RULE8
            end else if (inc0) begin
                cnt0_q <= cnt0_nx;
            end
            if (apply && clr_go_q[1]) begin
                cnt1_q <= 16'h0; // RULE8
            end else if (inc1) begin
                cnt1_q <= cnt1_nx;
            end
            if (apply && clr_go_q[2]) begin
                cnt2_q <= 32'h0; // RULE8
            end else if (inc2) begin
                cnt2_q <= cnt2_nx;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sticky status, write one to clear; a same-cycle event wins
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            stat_q <= 3'h0;
        end else begin
            stat_q <= (stat_q & ~w1c) | ev; // RULE9
        end
    end

    assign irq_any = |(stat_q & mask_q);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            irq_cpu_q <= 1'b0;
            irq_wic_q <= 1'b0;
        end else begin
            irq_cpu_q <= irq_any & (pwr_mode == dswt_pkg::DSWT_PWR_ACTIVE); // RULE1
            irq_wic_q <= irq_any & (pwr_mode != dswt_pkg::DSWT_PWR_ACTIVE); // RULE2
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Count reads hidden until the first source edge after deep sleep
    assign deep_exit = (pwr_prev_q == dswt_pkg::DSWT_PWR_DEEP)
                     & (pwr_mode != dswt_pkg::DSWT_PWR_DEEP);

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            pwr_prev_q <= dswt_pkg::DSWT_PWR_ACTIVE;
            hide_q     <= 1'b0;
        end else begin
            pwr_prev_q <= pwr_mode;
            if (deep_exit) begin
                hide_q <= 1'b1; // RULE3
            end else if (src_tick) begin
                hide_q <= 1'b0; // RULE3
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    cpu_route_a: assert property (irq_any && pwr_mode == dswt_pkg::DSWT_PWR_ACTIVE // RULE1
        |=> irq_cpu_q && !irq_wic_q) else $error("Active interrupt not sent to processor");

    wic_route_a: assert property (irq_any && pwr_mode != dswt_pkg::DSWT_PWR_ACTIVE // RULE2
        |=> irq_wic_q && !irq_cpu_q) else $error("Sleep interrupt not sent to wake controller");

    hide_after_a: assert property (deep_exit |=> hide_q) // RULE3
        else $error("Count not hidden after deep-sleep exit");

    tick_select_a: assert property (!cfg_act_q.clk_sel && ilo_tick && cfg_act_q.en[0] // RULE5
        && !apply |=> cnt0_q == $past(cnt0_q) + 16'h1) else $error("Counter missed source edge");

    cfg_hold_a: assert property (!apply |=> $stable(cfg_act_q)) // RULE6
        else $error("Active config changed without apply");

    apply_count_a: assert property (apply |-> $past(st_q) == dswt_pkg::DSWT_ST_WAIT // RULE6
        && wait_cnt_q == LAST_TICK) else $error("Apply before three source edges");

    clr_sel_a: assert property (apply && clr_go_q[1] && !clr_go_q[0] && !inc0 // RULE8
        |=> cnt1_q == 16'h0 && cnt0_q == $past(cnt0_q)) else $error("Counter clear not selective");

    sticky_a: assert property (stat_q[0] && !w1c[0] |=> stat_q[0]) // RULE9
        else $error("Pending interrupt dropped without clear");

    set_wins_a: assert property (ev0 && w1c[0] |=> stat_q[0]) // RULE9
        else $error("Event lost against clear");

    clr_keep_a: assert property (clr_wr[2] |=> clr_pend_q[2] || clr_go_q[2]) // RULE15
        else $error("Counter clear request lost");

endmodule // dswt_top

// >>> dv/dswt_partner.sv
// Far-side model: slow oscillators, processor power state and wake controller
module dswt_partner (
    input  wire logic                clk_sys,
    input  wire logic                arst_n,
    input  wire logic                ilo_on,
    input  wire dswt_pkg::dswt_pwr_t mode_req,
    input  wire logic                irq_wic,
    output logic                     ilo_clk,
    output logic                     wco_clk,
    output dswt_pkg::dswt_pwr_t      pwr_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    dswt_pkg::dswt_pwr_t req_q;
    logic                ilo_q = 1'b0;
    ////////////////////////////////////////
    // Rates scaled far above 32 kHz to keep the run short
    initial begin
        wco_clk = 1'b0;
        forever #500 wco_clk = ~wco_clk;
    end
    initial forever #610 ilo_q = ~ilo_q;
    assign ilo_clk = ilo_q & ilo_on;
    ////////////////////////////////////////
    // Wake controller pulls the processor back to active on a request
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            req_q    <= dswt_pkg::DSWT_PWR_ACTIVE;
            pwr_mode <= dswt_pkg::DSWT_PWR_ACTIVE;
        end else begin
            req_q <= mode_req;
            if (mode_req != req_q) begin
                pwr_mode <= mode_req;
            end else if (irq_wic && pwr_mode != dswt_pkg::DSWT_PWR_ACTIVE) begin
                pwr_mode <= dswt_pkg::DSWT_PWR_ACTIVE;
            end
        end
    end
endmodule // dswt_partner

// >>> dv/dswt_tb_top.sv
// Self-checking bench for the deep-sleep wake-up timer
`include "dswt_defs.svh"
module dswt_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                clk_sys  = 1'b0;
    logic                arst_n   = 1'b0;
    logic                psel     = 1'b0;
    logic                penable  = 1'b0;
    logic                pwrite   = 1'b0;
    logic [11:0]         paddr    = 12'h000;
    logic [31:0]         pwdata   = 32'h0;
    logic                ilo_on   = 1'b1;
    dswt_pkg::dswt_pwr_t mode_req = dswt_pkg::DSWT_PWR_ACTIVE;
    dswt_pkg::dswt_pwr_t pwr_mode;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
    logic                ilo_clk;
    logic                wco_clk;
    logic                irq_cpu;
    logic                irq_wic;
    logic [65:0]         notes_q[$];
    logic [65:0]         note;
    logic [31:0]         junk;
    logic [31:0]         v1;
    logic [15:0]         m;
    logic [4:0]          t;
    int unsigned         seed_v;
    int                  miscompares = 0;
    int                  samples_checked = 0;

    dswt_top #(.APPLY_TICKS(3)) dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .ilo_clk_in(ilo_clk),
        .wco_clk_in(wco_clk), .pwr_mode(pwr_mode), .irq_cpu(irq_cpu), .irq_wic(irq_wic)
    );
    dswt_partner partner_u (
        .clk_sys(clk_sys), .arst_n(arst_n), .ilo_on(ilo_on), .mode_req(mode_req),
        .irq_wic(irq_wic), .ilo_clk(ilo_clk), .wco_clk(wco_clk), .pwr_mode(pwr_mode)
    );
    initial forever #10 clk_sys = ~clk_sys;
    ////////////////////////////////////////
    task automatic check(input string what, input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("Comparisons %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // Oldest note is matched against each completed transfer
    always @(posedge clk_sys) begin
        if (psel && penable && pready === 1'b1) begin
            note = notes_q.pop_front();
            if (note[32:0] != 33'h0) begin
                check("apb", {pslverr, prdata} & note[32:0], note[65:33] & note[32:0]);
            end
        end
    end
    ////////////////////////////////////////
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e, input logic [32:0] k, output logic [31:0] r);
        @(posedge clk_sys);
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        notes_q.push_back({e, k});
        @(posedge clk_sys);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        r = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0, {1'b1, 32'h0}, junk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, {1'b0, e}, {33{1'b1}}, junk);
    endtask
    // Polls are bounded; a stuck apply shows as a mismatch
    task automatic wait_idle();
        logic [31:0] s;
        s = 32'h2;
        for (int i = 0; i < 200 && s[`DSWT_STAT_BUSY]; i++) begin
            apb(1'b0, `DSWT_OFF_STATUS, 32'h0, 33'h0, 33'h0, s);
        end
        check("busy", {32'h0, s[`DSWT_STAT_BUSY]}, 33'h0);
    endtask
    task automatic wait_irq(input logic wakeup_irq_controller);
        for (int i = 0; i < 4000 && (wakeup_irq_controller ? irq_wic : irq_cpu) !== 1'b1; i++) begin
            @(posedge clk_sys);
        end
    endtask
    task automatic clean();
        wr(`DSWT_OFF_CLEAR, 32'h7);
        wait_idle();
        wr(`DSWT_OFF_INT_STAT, 32'h7);
        repeat (2) @(posedge clk_sys);
        check("irq_clr", {31'h0, irq_cpu, irq_wic}, 33'h0);
        rd(`DSWT_OFF_CNT2, 32'h0);
    endtask
    task automatic run_case(input logic [31:0] ctrl, input logic [15:0] m0,
                            input logic [11:0] ca, input logic [31:0] cv, input logic [2:0] st);
        wr(`DSWT_OFF_MATCH0, {16'h0, m0});
        wr(`DSWT_OFF_MATCH1, 32'h1);
        wr(`DSWT_OFF_CTRL, ctrl);
        apb(1'b0, `DSWT_OFF_STATUS, 32'h0, 33'h2, 33'h2, junk);
        rd(ca, 32'h0);
        wait_idle();
        ilo_on <= ~ctrl[`DSWT_CTRL_SEL];
        wait_irq(1'b0);
        check("irq_cpu", {32'h0, irq_cpu}, 33'h1);
        rd(ca, cv);
        rd(`DSWT_OFF_INT_STAT, {29'h0, st});
        wr(`DSWT_OFF_INT_MASK, 32'h0);
        repeat (2) @(posedge clk_sys);
        check("masked", {32'h0, irq_cpu}, 33'h0);
        wr(`DSWT_OFF_INT_MASK, 32'h7);
        repeat (100) @(posedge clk_sys);
        check("held", {32'h0, irq_cpu}, 33'h1);
        ilo_on <= 1'b1;
        wr(`DSWT_OFF_CTRL, 32'h0);
        wait_idle();
    endtask
    ////////////////////////////////////////
    initial begin
        repeat (80000) @(posedge clk_sys);
        miscompares++;
        wrap_up();
    end
    initial begin
        seed_v = $urandom(26);
        repeat (20) @(posedge clk_sys);
        arst_n <= 1'b1;
        rd(`DSWT_OFF_CTRL, {19'h0, `DSWT_TBIT_RST, 8'h00});
        rd(`DSWT_OFF_MATCH1, {16'h0, `DSWT_MATCH_RST});
        rd(`DSWT_OFF_STATUS, 32'h0);
        apb(1'b1, 12'h028, 32'h1, {1'b1, 32'h0}, {1'b1, 32'h0}, junk);
        apb(1'b0, 12'h030, 32'h0, {1'b1, 32'h0}, {33{1'b1}}, junk);
        wr(`DSWT_OFF_INT_MASK, 32'h7);
        m = 16'(2 + $urandom_range(3));
        run_case(32'h2, m, `DSWT_OFF_CNT0, {16'h0, m}, 3'h1);
        mode_req <= dswt_pkg::DSWT_PWR_SLEEP;
        wait_irq(1'b1);
        check("to_wic", {31'h0, irq_cpu, irq_wic}, 33'h1);
        wait_irq(1'b0);
        check("to_cpu", {31'h0, irq_cpu, irq_wic}, 33'h2);
        mode_req <= dswt_pkg::DSWT_PWR_ACTIVE;
        clean();
        run_case(32'h16, m, `DSWT_OFF_CNT0, {16'h0, m + 16'h1}, 3'h3);
        apb(1'b0, `DSWT_OFF_CNT1, 32'h0, 33'h0, 33'h0, v1);
        wr(`DSWT_OFF_INT_STAT, 32'h7);
        wr(`DSWT_OFF_CLEAR, 32'h1);
        wait_idle();
        rd(`DSWT_OFF_CNT0, 32'h0);
        rd(`DSWT_OFF_CNT1, v1);
        @(posedge ilo_clk);
        repeat (6) @(posedge clk_sys);
        mode_req <= dswt_pkg::DSWT_PWR_DEEP;
        repeat (2) @(posedge clk_sys);
        mode_req <= dswt_pkg::DSWT_PWR_ACTIVE;
        repeat (2) @(posedge clk_sys);
        rd(`DSWT_OFF_STATUS, 32'h1);
        rd(`DSWT_OFF_CNT1, 32'h0);
        @(posedge ilo_clk);
        repeat (6) @(posedge clk_sys);
        rd(`DSWT_OFF_CNT1, v1);
        clean();
        t = 5'(1 + $urandom_range(2));
        run_case({19'h0, t, 8'h08}, 16'hffff, `DSWT_OFF_CNT2, 32'h1 << t, 3'h4);
        clean();
        run_case(32'h3, m, `DSWT_OFF_CNT0, {16'h0, m}, 3'h1);
        clean();
        wrap_up();
    end
endmodule // dswt_tb_top
